/* File: logic/serial_dac_command_logic.v */
// Command decoder and register pair of a serial 10-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_map.vh"
module serial_dac_command_logic (
    input  wire                 clk_i,
    input  wire                 reset_i,
    input  wire                 enable_i,
    input  wire                 cs_n_i,
    input  wire                 sclk_i,
    input  wire                 din_i,
    output reg  [`CODE_W-1:0]   input_code_o,
    output reg  [`CODE_W-1:0]   code_value_o,
    output reg                  shutdown_o,
    output reg  [2:0]           sub_bit_field_o,
    output reg                  frame_error_o,
    output reg                  commit_o
);
    wire                    cs_n_sync;
    wire                    sclk_sync;
    wire                    din_sync;
    reg                     sclk_prev_reg;
    reg                     cs_n_prev_reg;
    reg  [`FRAME_BITS-1:0]  shift_reg;
    reg  [`BIT_COUNT_W-1:0] count_reg;
    wire                    sclk_rise;
    wire                    cs_rise;
    wire                    ctrl_bit_high;
    wire [1:0]              ctrl_low_pair;
    wire [`CODE_W-1:0]      code_field;
    wire [2:0]              sub_bit_field;
    wire                    frame_full;

    // Next-state values for every register but the edge history
    reg  [`FRAME_BITS-1:0]  shift_next;
    reg  [`BIT_COUNT_W-1:0] count_next;
    wire                    shift_take;
    wire                    word_commit;
    reg  [`CODE_W-1:0]      input_code_next;
    reg  [`CODE_W-1:0]      code_value_next;
    reg                     shutdown_next;
    reg  [2:0]              sub_bits_next;
    reg                     frame_error_next;
    reg                     commit_next;

    // Serial clock is slow against clk_i, so edges are found by sampling
    // Limitation: each serial clock phase must last three clk_i periods
    pin_sync #(.RESET_VALUE(1'b1)) cs_sync_u (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .pin_i    (cs_n_i),
        .sync_o   (cs_n_sync)
    );
    pin_sync #(.RESET_VALUE(1'b0)) sclk_sync_u (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .pin_i    (sclk_i),
        .sync_o   (sclk_sync)
    );
    pin_sync #(.RESET_VALUE(1'b0)) din_sync_u (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .pin_i    (din_i),
        .sync_o   (din_sync)
    );

    assign sclk_rise     = sclk_sync & ~sclk_prev_reg;
    assign cs_rise       = cs_n_sync & ~cs_n_prev_reg;
    assign frame_full    = (count_reg == `BIT_COUNT_FULL);
    assign ctrl_bit_high = shift_reg[`CTRL_HIGH_POS];
    assign ctrl_low_pair = {shift_reg[`CTRL_MID_POS],
                            shift_reg[`CTRL_LOW_POS]};
    assign code_field    = shift_reg[`CODE_MSB_POS:`CODE_LSB_POS];
    assign sub_bit_field = shift_reg[`SUB_MSB_POS:`SUB_LSB_POS];
    assign shift_take    = ~cs_n_sync & sclk_rise;
    assign word_commit   = cs_rise & frame_full;

    // Edge history; reset levels match the idle pins so that no false
    // edge follows reset
    always @(posedge clk_i) begin
        if (reset_i) begin
            sclk_prev_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
        end else if (enable_i) begin
            sclk_prev_reg <= sclk_sync;
            cs_n_prev_reg <= cs_n_sync;
        end
    end

    // Shifter and bit counter; the count saturates so that a long frame
    // keeps its last 16 bits
    always @* begin
        shift_next = shift_reg;
        count_next = count_reg;
        // Deselected device ignores shared clock and data lines
        if (shift_take) begin
            shift_next = {shift_reg[`FRAME_BITS-2:0], din_sync};
            if (!frame_full) begin
                count_next = count_reg + `BIT_COUNT_ONE;
            end
        end
        if (cs_rise) begin
            count_next = `BIT_COUNT_ZERO;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            shift_reg <= `WORD_ZERO;
            count_reg <= `BIT_COUNT_ZERO;
        end else if (enable_i) begin
            shift_reg <= shift_next;
            count_reg <= count_next;
        end
    end

    // Command decode; recall uses the input register as it stood before
    // this frame, since no command loads and recalls at once
    always @* begin
        input_code_next = input_code_o;
        code_value_next = code_value_o;
        shutdown_next   = shutdown_o;
        sub_bits_next   = sub_bit_field_o;
        if (word_commit) begin
            sub_bits_next = sub_bit_field;
            case (ctrl_low_pair)
                `OP_LOAD_UPDATE: begin
                    input_code_next = code_field;
                    code_value_next = code_field;
                    shutdown_next   = 1'b0;
                end
                `OP_LOAD_ONLY: begin
                    input_code_next = code_field;
                end
                `OP_RECALL: begin
                    code_value_next = input_code_o;
                    shutdown_next   = 1'b0;
                end
                default: begin
                    // Input register untouched in shutdown
                    if (ctrl_bit_high) begin
                        shutdown_next = 1'b1;
                    end
                    // Else no-operation: only the sub-bit field is taken from the frame
                end
            endcase
        end
    end

    // Short frames are dropped rather than half-decoded
    always @* begin
        frame_error_next = frame_error_o;
        commit_next      = 1'b0;
        if (cs_rise) begin
            frame_error_next = ~frame_full;
            commit_next      = frame_full;
        end
    end

    // Input register
    always @(posedge clk_i) begin
        if (reset_i) begin
            input_code_o <= `CODE_ZERO;
        end else if (enable_i) begin
            input_code_o <= input_code_next;
        end
    end

    // Output register feeding the converter
    always @(posedge clk_i) begin
        if (reset_i) begin
            code_value_o <= `CODE_ZERO;
        end else if (enable_i) begin
            code_value_o <= code_value_next;
        end
    end

    // Shutdown mode
    always @(posedge clk_i) begin
        if (reset_i) begin
            shutdown_o <= 1'b0;
        end else if (enable_i) begin
            shutdown_o <= shutdown_next;
        end
    end

    // Sub-bits of the last committed frame
    always @(posedge clk_i) begin
        if (reset_i) begin
            sub_bit_field_o <= 3'h0;
        end else if (enable_i) begin
            sub_bit_field_o <= sub_bits_next;
        end
    end

    // Frame status
    always @(posedge clk_i) begin
        if (reset_i) begin
            frame_error_o <= 1'b0;
            commit_o      <= 1'b0;
        end else if (enable_i) begin
            frame_error_o <= frame_error_next;
            commit_o      <= commit_next;
        end
    end
endmodule // serial_dac_command_logic
`default_nettype wire

/* File: shared/dac_cmd_map.vh */
// Constants for the serial converter command logic
`ifndef DAC_CMD_MAP_VH
`define DAC_CMD_MAP_VH
`define FRAME_BITS        16
`define BIT_COUNT_W       5
`define BIT_COUNT_ZERO    5'h00
`define BIT_COUNT_FULL    5'h10
`define BIT_COUNT_ONE     5'h01
`define CODE_W            10
`define CODE_ZERO         10'h000
`define WORD_ZERO         16'h0000
`define CTRL_HIGH_POS     15
`define CTRL_MID_POS      14
`define CTRL_LOW_POS      13
`define CODE_MSB_POS      12
`define CODE_LSB_POS      3
`define SUB_MSB_POS       2
`define SUB_LSB_POS       0
`define OP_LOAD_UPDATE    2'h0
`define OP_LOAD_ONLY      2'h1
`define OP_RECALL         2'h2
`define OP_SPECIAL        2'h3
`endif

/* File: logic/pin_sync.v */
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire clk_i,
    input  wire reset_i,
    input  wire enable_i,
    input  wire pin_i,
    output reg  sync_o
);
    reg meta_reg;

    always @(posedge clk_i) begin
        if (reset_i) begin
            meta_reg <= RESET_VALUE;
            sync_o   <= RESET_VALUE;
        end else if (enable_i) begin
            meta_reg <= pin_i;
            sync_o   <= meta_reg;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* File: testbench/dac_cmd_properties.sv */
// Port assertions for the converter command logic
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_properties (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic [9:0] input_code_o,
    input wire logic [9:0] code_value_o,
    input wire logic       shutdown_o,
    input wire logic       frame_error_o,
    input wire logic       commit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // A real frame takes far longer than eight clocks
    sequence quiet; !commit_o [*8]; endsequence
    state_hold_a: assert property (!commit_o |->
        $stable({input_code_o, code_value_o, shutdown_o})) else $error("moved");
    reset_clear_a: assert property ($fell(reset_i) |->
        !{input_code_o, code_value_o, commit_o}) else $error("not cleared");
    commit_pulse_a: assert property (commit_o |=> quiet)
        else $error("commit too long");
    out_copy_a: assert property ($changed(code_value_o) |->
        code_value_o == input_code_o) else $error("output not input");
    wake_copy_a: assert property ($fell(shutdown_o) |->
        commit_o && code_value_o == input_code_o) else $error("bad wake");
    sleep_keep_a: assert property ($rose(shutdown_o) |-> commit_o
        && $stable({input_code_o, code_value_o})) else $error("bad sleep");
    shutdown_hold_a: assert property (commit_o && shutdown_o
        && $past(shutdown_o) |-> $stable(code_value_o)) else $error("woke");
    good_frame_a: assert property (commit_o |-> !frame_error_o)
        else $error("error flag on good frame");
endmodule // dac_cmd_properties
bind serial_dac_command_logic dac_cmd_properties props (.clk_i, .reset_i,
    .input_code_o, .code_value_o, .shutdown_o, .frame_error_o, .commit_o);
`default_nettype wire

/* File: testbench/spi_host_model.sv */
// Serial host model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk_i,
    output logic     cs_n_o,
    output logic     sclk_o,
    output logic     din_o
);
    initial {cs_n_o, sclk_o, din_o} = 3'h4;
    // Eight clocks per half period make the 64 ns link clock
    task automatic send(input logic [15:0] w, input int n, input logic s);
        @(posedge clk_i);
        cs_n_o <= !s;
        for (int i = 0; i < n; i++) begin
            din_o <= w[15 - i];
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        cs_n_o <= 1'b1;
        din_o <= !din_o;
        repeat (12) @(posedge clk_i);
    endtask
endmodule // spi_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the converter command logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       enable_i = 1'b1;
    logic       cs_n, sclk, din, sd, err;
    logic [9:0] in_code, out_code;
    logic [2:0] sub;
    int         fail_count = 0;
    int         check_count = 0;
    always #2 clk_i = ~clk_i;
    spi_host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
        .din_o(din));
    serial_dac_command_logic dut (.clk_i(clk_i), .reset_i(reset_i),
        .enable_i(enable_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
        .input_code_o(in_code), .code_value_o(out_code), .shutdown_o(sd),
        .sub_bit_field_o(sub), .frame_error_o(err), .commit_o());
    task automatic chk(input string nm, input logic [21:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run(input logic [15:0] w, input int n, input logic s,
                       input logic [21:0] e);
        host.send(w, n, s);
        chk("state", {in_code, out_code, sd, err}, e);
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("reset", {in_code, out_code, sd, err}, 22'h0);
        run(16'h9FF8, 16, 1, {10'h3FF, 10'h3FF, 2'h0});
        run(16'h2AA8, 16, 1, {10'h155, 10'h3FF, 2'h0});
        run(16'hFFFF, 16, 1, {10'h155, 10'h3FF, 2'h2});
        chk("sub", sub, 22'h7);
        run(16'hB008, 16, 1, {10'h201, 10'h3FF, 2'h2});
        run(16'h7FFF, 16, 1, {10'h201, 10'h3FF, 2'h2});
        run(16'h5555, 16, 1, {10'h201, 10'h201, 2'h0});
        chk("sub", sub, 22'h5);
        run(16'h0000, 12, 1, {10'h201, 10'h201, 2'h1});
        chk("sub", sub, 22'h5);
        run(16'h0008, 16, 1, {10'h001, 10'h001, 2'h0});
        chk("sub", sub, 22'h0);
        run(16'h9FF8, 16, 0, {10'h001, 10'h001, 2'h0});
        // Clock enable low freezes the block through a whole frame
        enable_i <= 1'b0;
        run(16'h9FF8, 16, 1, {10'h001, 10'h001, 2'h0});
        enable_i <= 1'b1;
        reset_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("reset", {in_code, out_code, sd, err}, 22'h0);
        run(16'h2AA8, 16, 1, {10'h155, 10'h000, 2'h0});
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
